// file: hdl/eid_regs.svh
// Object indexes, codes, reset values and timing for encoder diagnostics.
//
// Overview of operation
// R1 - Supply absent: failure flag true, supply LED off, message 0x8303; else LED green.
// R2 - Status input high or open reads true, LED off; pulled low reads false, LED red.
// R3 - Status input overvoltage sets error flag, red LED, error message 0x8315.
// R4 - Tracks A and B are quadrature; simultaneous changes of both are invalid.
// R5 - Invalid transitions are detected and reported only while plausibility check enabled.
// R6 - Implausible transitions never step the position count.
// R7 - Each plausibility error increments the channel counter and sends message 0x8312.
// R8 - A plausibility error sets the channel's process data invalid bit.
// R9 - Plausibility counters clear when communication passes from pre-operational to operational.
// R10 - A request code in the command object zeroes channel 1 or channel 2 counter.
// R11 - With the track filter active, each frequency overrun increments the track counter; overruns on A and B in the same cycle add only one.
// R12 - Each channel counts filter overruns on its latch input separately.
// R13 - Each channel counts filter overruns on its gate input separately.
// R14 - Status input filter is fixed; latch and gate filters stay within 1 MHz.
// R15 - Track filters stay within the recommended frequency of each input mode.
// R16 - Restore magic value returns settings to defaults; any other value does nothing.
// R17 - With filter active, a track level counts only after persisting 2.4 us.
// R18 - Event counters saturate instead of wrapping and are zero after power-up.
// R19 - Each channel keeps its own flags and counters, driven by its own inputs.
`ifndef EID_REGS_SVH
`define EID_REGS_SVH

// ==========================================================================
// Object indexes and subindexes
`define EID_IDX_STAT 16'h6000
`define EID_SUB_STAT_IN 8'h06
`define EID_SUB_POS 8'h11
`define EID_IDX_PD 16'h6002
`define EID_SUB_PD_INV 8'h0E
`define EID_IDX_SET 16'h8000
`define EID_SUB_DIS_FILT 8'h08
`define EID_SUB_PLAUS_EN 8'h21
`define EID_IDX_SET2 16'h8001
`define EID_SUB_LG_FILT 8'h19
`define EID_IDX_DIAG 16'hA000
`define EID_SUB_SUP_FAIL 8'h04
`define EID_SUB_STAT_ERR 8'h05
`define EID_SUB_PLAUS_CNT 8'h13
`define EID_SUB_LAT_VIOL 8'h14
`define EID_SUB_GATE_VIOL 8'h15
`define EID_SUB_ENC_VIOL 8'h16
`define EID_IDX_CMD 16'hFB00
`define EID_SUB_REQ 8'h01
`define EID_IDX_RESTORE 16'h1011
`define EID_SUB_RST_CNT 8'h00
`define EID_SUB_RST_CMD 8'h01
`define EID_CH_BIT 4

// ==========================================================================
// Codes and reset values
`define EID_RESTORE_MAGIC 32'h64616F6C
`define EID_RESTORE_ENTRIES 8'h01
`define EID_REQ_CLR_CH1 32'h00000001
`define EID_REQ_CLR_CH2 32'h00000002
`define EID_TXT_SUPPLY 16'h8303
`define EID_TXT_STAT_OV 16'h8315
`define EID_TXT_PLAUS 16'h8312
`define EID_DEF_DIS_FILT 1'b1
`define EID_DEF_PLAUS_EN 1'b0
`define EID_DEF_LG_FILT 1'b0

// ==========================================================================
// Timing in ns, cycles derived from the clock rate.
`define EID_CLK_MHZ 125
`define EID_ENC_QUAL_NS 2400
`define EID_LG_QUAL_NS 500
`define EID_STAT_QUAL_NS 5000
`define EID_NS2CYC(ns) (((ns) * `EID_CLK_MHZ + 999) / 1000)
`define EID_ENC_QUAL_CYC `EID_NS2CYC(`EID_ENC_QUAL_NS)
`define EID_LG_QUAL_CYC `EID_NS2CYC(`EID_LG_QUAL_NS)
`define EID_STAT_QUAL_CYC `EID_NS2CYC(`EID_STAT_QUAL_NS)

`endif

// file: hdl/eid_pkg.sv
// Types shared by the encoder diagnostics design.
package eid_pkg;

  // Communication state, Gray coded along init, preop, safeop, op.
  typedef enum logic [1:0] {
    EID_INIT = 2'h0,
    EID_PREOP = 2'h1,
    EID_SAFEOP = 2'h3,
    EID_OP = 2'h2
  } eid_comm_e;

  // Per-channel settings written by the master.
  typedef struct packed {
    logic dis_filt;
    logic plaus_en;
    logic lg_filt_en;
  } eid_cfg_s;

  // One diagnostic message on its way out.
  typedef struct packed {
    logic valid;
    logic is_error;
    logic chan;
    logic [15:0] text_id;
  } eid_diag_s;

endpackage

// file: hdl/eid_filt.sv
// Input qualification filter with overrun pulse.
`timescale 1ns/1ps
`default_nettype none

module eid_filt #(
  parameter int QUAL = 300
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic din,
  output logic q,
  output logic viol
);

  localparam int CW = $clog2(QUAL + 1);

  logic [CW-1:0] cnt_r;
  logic q_r;
  logic viol_r;

  // ==========================================================================
  // Qualification
  // A new level must hold QUAL cycles; returning early is an overrun.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      q_r <= 1'b0;
      viol_r <= 1'b0;
    end
    else if (!en)
    begin
      cnt_r <= '0;
      q_r <= din;
      viol_r <= 1'b0;
    end
    else if (din == q_r)
    begin
      viol_r <= (cnt_r != '0);
      cnt_r <= '0;
    end
    else if (cnt_r == CW'(QUAL - 1))
    begin
      q_r <= din; // see R17
      cnt_r <= '0;
      viol_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      viol_r <= 1'b0;
    end
  end

  assign q = q_r;
  assign viol = viol_r;

endmodule

`default_nettype wire

// file: hdl/eid_top.sv
// Two-channel encoder input diagnostics with object dictionary access.
`timescale 1ns/1ps
`default_nettype none
`include "eid_regs.svh"

module eid_top #(
  parameter int CW = 16,
  parameter int PW = 32
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [1:0] ENC_A,
  input wire logic [1:0] ENC_B,
  input wire logic [1:0] LATCH_IN,
  input wire logic [1:0] GATE_IN,
  input wire logic [1:0] STATUS_IN,
  input wire logic [1:0] ENC_SUPPLY_OK,
  input wire logic [1:0] STATUS_OVERVOLT,
  input wire logic [1:0] COMM_STATE,
  input wire logic OD_WR,
  input wire logic OD_RD,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUB,
  input wire logic [31:0] OD_WDATA,
  output logic [31:0] OD_RDATA,
  output logic OD_ACK,
  output logic OD_ERR,
  output logic [1:0] LED_SUPPLY_GREEN,
  output logic [1:0] LED_STATUS_RED,
  output logic [1:0] PD_INVALID,
  output var eid_pkg::eid_diag_s DIAG
);

  localparam int NCH = 2;
  localparam int NEV = 3;
  localparam int ENC_Q = `EID_ENC_QUAL_CYC;
  localparam int LG_Q = `EID_LG_QUAL_CYC;
  localparam int STAT_Q = `EID_STAT_QUAL_CYC;

  // Saturating increment for all event counters.
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1; // see R18
  endfunction

  // ==========================================================================
  // Reset release and pin synchronisers
  logic rst_s1_r;
  logic rst_n;

  // Reset enters asynchronously but is released through two flops.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  logic [13:0] pin_s1_r;
  logic [13:0] pin_s2_r;

  // Every track, latch, gate, status and supply pin passes two flops; only the second copy is read.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {ENC_A, ENC_B, LATCH_IN, GATE_IN, STATUS_IN,
                   ENC_SUPPLY_OK, STATUS_OVERVOLT};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [1:0] a_s, b_s, lat_s, gate_s, stat_s, sup_s, ov_s;
  assign {a_s, b_s, lat_s, gate_s, stat_s, sup_s, ov_s} = pin_s2_r;

  // ==========================================================================
  // Object access decode
  logic od_ch;
  logic [15:0] od_base;
  logic restore_go;
  logic [NCH-1:0] clr_req;
  logic [31:0] restore_val_r;

  assign od_ch = OD_INDEX[`EID_CH_BIT];
  assign od_base = OD_INDEX & ~(16'h1 << `EID_CH_BIT);
  // Only the exact magic value triggers a restore.
  assign restore_go = OD_WR && OD_INDEX == `EID_IDX_RESTORE &&
                      OD_SUB == `EID_SUB_RST_CMD &&
                      OD_WDATA == `EID_RESTORE_MAGIC; // see R16
  // Request codes zero one channel's plausibility counter.
  assign clr_req[0] = OD_WR && OD_INDEX == `EID_IDX_CMD &&
                      OD_SUB == `EID_SUB_REQ &&
                      OD_WDATA == `EID_REQ_CLR_CH1; // see R10
  assign clr_req[1] = OD_WR && OD_INDEX == `EID_IDX_CMD &&
                      OD_SUB == `EID_SUB_REQ &&
                      OD_WDATA == `EID_REQ_CLR_CH2; // see R10

  // The restore object keeps whatever value was last written.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      restore_val_r <= '0;
    else if (OD_WR && OD_INDEX == `EID_IDX_RESTORE &&
             OD_SUB == `EID_SUB_RST_CMD)
      restore_val_r <= OD_WDATA;
  end

  // ==========================================================================
  // Communication state tracking
  eid_pkg::eid_comm_e comm;
  eid_pkg::eid_comm_e comm_p_r;
  logic from_preop_r;
  logic op_entry;

  assign comm = eid_pkg::eid_comm_e'(COMM_STATE);
  assign op_entry = comm == eid_pkg::EID_OP &&
                    comm_p_r != eid_pkg::EID_OP && from_preop_r;

  // Remember that the path to operational started in pre-operational.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comm_p_r <= eid_pkg::EID_INIT;
      from_preop_r <= 1'b0;
    end
    else
    begin
      comm_p_r <= comm;
      if (comm == eid_pkg::EID_PREOP)
        from_preop_r <= 1'b1;
      else if (comm == eid_pkg::EID_INIT || comm == eid_pkg::EID_OP)
        from_preop_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Channel logic
  eid_pkg::eid_cfg_s cfg_r [NCH];
  logic [CW-1:0] plaus_cnt_r [NCH];
  logic [CW-1:0] enc_viol_r [NCH];
  logic [CW-1:0] lat_viol_r [NCH];
  logic [CW-1:0] gate_viol_r [NCH];
  logic [PW-1:0] pos_r [NCH];
  logic [NCH-1:0] sup_fail_r, stat_err_r, stat_true_r, pd_inv_r;
  logic [NCH-1:0] led_sup_r, led_stat_r;
  logic [NCH*NEV-1:0] evt;

  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_ch
    logic enc_en, a_q, b_q, a_v, b_v, lat_v, gate_v, stat_q;
    logic a_p_r, b_p_r, sup_p_r, ov_p_r;
    logic a_chg, b_chg, bad, perr, cfg_wr, clr;

    assign enc_en = ~cfg_r[ch].dis_filt;
    assign cfg_wr = OD_WR && od_ch == ch;
    assign clr = clr_req[ch] | op_entry; // see R9

    // Track filters qualify at 2.4 us, within every mode's
    // recommended ceiling for interference rejection.
    eid_filt #(.QUAL(ENC_Q)) u_fa (
      .clk(CLK), .rst_n(rst_n), .en(enc_en), .din(a_s[ch]),
      .q(a_q), .viol(a_v)); // see R15
    eid_filt #(.QUAL(ENC_Q)) u_fb (
      .clk(CLK), .rst_n(rst_n), .en(enc_en), .din(b_s[ch]),
      .q(b_q), .viol(b_v));
    // Latch and gate filters are set to the 1 MHz recommendation.
    eid_filt #(.QUAL(LG_Q)) u_fl (
      .clk(CLK), .rst_n(rst_n), .en(cfg_r[ch].lg_filt_en),
      .din(lat_s[ch]), .q(), .viol(lat_v)); // see R14
    eid_filt #(.QUAL(LG_Q)) u_fg (
      .clk(CLK), .rst_n(rst_n), .en(cfg_r[ch].lg_filt_en),
      .din(gate_s[ch]), .q(), .viol(gate_v));
    // The status filter is always on at a fixed limit.
    eid_filt #(.QUAL(STAT_Q)) u_fs (
      .clk(CLK), .rst_n(rst_n), .en(1'b1), .din(stat_s[ch]),
      .q(stat_q), .viol()); // see R14

    // Both tracks moving in one step is not a quadrature transition.
    assign a_chg = a_q ^ a_p_r;
    assign b_chg = b_q ^ b_p_r;
    assign bad = a_chg & b_chg; // see R4
    assign perr = bad & cfg_r[ch].plaus_en; // see R5
    assign evt[ch*NEV +: NEV] = {perr, ov_s[ch] & ~ov_p_r,
                                 sup_p_r & ~sup_s[ch]};

    // Per-channel settings, restored on the magic value.
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
        cfg_r[ch] <= '{`EID_DEF_DIS_FILT, `EID_DEF_PLAUS_EN,
                       `EID_DEF_LG_FILT};
      else if (restore_go)
        cfg_r[ch] <= '{`EID_DEF_DIS_FILT, `EID_DEF_PLAUS_EN,
                       `EID_DEF_LG_FILT}; // see R16
      else if (cfg_wr && od_base == `EID_IDX_SET &&
               OD_SUB == `EID_SUB_DIS_FILT)
        cfg_r[ch].dis_filt <= OD_WDATA[0];
      else if (cfg_wr && od_base == `EID_IDX_SET &&
               OD_SUB == `EID_SUB_PLAUS_EN)
        cfg_r[ch].plaus_en <= OD_WDATA[0];
      else if (cfg_wr && od_base == `EID_IDX_SET2 &&
               OD_SUB == `EID_SUB_LG_FILT)
        cfg_r[ch].lg_filt_en <= OD_WDATA[0];
    end

    // Position count; a double step is dropped, not guessed.
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        a_p_r <= 1'b0;
        b_p_r <= 1'b0;
        pos_r[ch] <= '0;
      end
      else
      begin
        a_p_r <= a_q;
        b_p_r <= b_q;
        if (a_chg ^ b_chg) // see R6
        begin
          if (a_chg ? (a_q ^ b_q) : ~(a_q ^ b_q))
            pos_r[ch] <= pos_r[ch] + 1'b1;
          else
            pos_r[ch] <= pos_r[ch] - 1'b1;
        end
      end
    end

    // Supply and status flags with their LEDs, all from this channel.
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sup_p_r <= 1'b1;
        ov_p_r <= 1'b0;
        sup_fail_r[ch] <= 1'b0;
        led_sup_r[ch] <= 1'b0;
        stat_true_r[ch] <= 1'b0;
        stat_err_r[ch] <= 1'b0;
        led_stat_r[ch] <= 1'b0;
      end
      else
      begin
        sup_p_r <= sup_s[ch]; // see R19
        ov_p_r <= ov_s[ch];
        sup_fail_r[ch] <= ~sup_s[ch]; // see R1
        led_sup_r[ch] <= sup_s[ch]; // see R1
        stat_true_r[ch] <= stat_q; // see R2
        stat_err_r[ch] <= ov_s[ch]; // see R3
        led_stat_r[ch] <= ~stat_q | ov_s[ch]; // see R2 see R3
      end
    end

    // Event counters; an event in the clearing cycle still counts.
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        plaus_cnt_r[ch] <= '0;
        pd_inv_r[ch] <= 1'b0;
        enc_viol_r[ch] <= '0;
        lat_viol_r[ch] <= '0;
        gate_viol_r[ch] <= '0;
      end
      else
      begin
        if (perr)
          plaus_cnt_r[ch] <= clr ? CW'(1) : sat_inc(plaus_cnt_r[ch]); // see R7
        else if (clr)
          plaus_cnt_r[ch] <= '0;
        if (perr)
          pd_inv_r[ch] <= 1'b1; // see R8
        else if (clr)
          pd_inv_r[ch] <= 1'b0;
        if (enc_en && (a_v || b_v))
          enc_viol_r[ch] <= sat_inc(enc_viol_r[ch]); // see R11
        if (lat_v)
          lat_viol_r[ch] <= sat_inc(lat_viol_r[ch]); // see R12
        if (gate_v)
          gate_viol_r[ch] <= sat_inc(gate_viol_r[ch]); // see R13
      end
    end
  end

  // ==========================================================================
  // Diagnostic message queue
  logic [NCH*NEV-1:0] pend_r;
  logic [NCH*NEV-1:0] pick;
  eid_pkg::eid_diag_s diag_r;
  eid_pkg::eid_diag_s diag_nxt;

  // Sticky pending bits hold a burst; an event that repeats while its bit is still pending gives one message.
  assign pick = pend_r & (~pend_r + 1'b1);

  // The lowest pending event goes out first.
  always_comb
  begin
    diag_nxt = '0;
    for (int i = 0; i < NCH * NEV; i++)
    begin
      if (pick[i])
      begin
        diag_nxt.valid = 1'b1;
        diag_nxt.chan = 1'(i / NEV);
        diag_nxt.is_error = (i % NEV) != 0;
        case (i % NEV)
          0: diag_nxt.text_id = `EID_TXT_SUPPLY; // see R1
          1: diag_nxt.text_id = `EID_TXT_STAT_OV; // see R3
          default: diag_nxt.text_id = `EID_TXT_PLAUS; // see R7
        endcase
      end
    end
  end

  // A new event wins over the bit sent in that cycle.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= '0;
      diag_r <= '0;
    end
    else
    begin
      pend_r <= (pend_r & ~pick) | evt;
      diag_r <= diag_nxt;
    end
  end

  // ==========================================================================
  // Object read and write answers
  logic [31:0] rd_nxt;
  logic hit_nxt;
  logic [31:0] rdata_r;
  logic ack_r, err_r;

  // Decode one object; read-only writes are refused.
  always_comb
  begin
    rd_nxt = '0;
    hit_nxt = 1'b1;
    unique case ({od_base, OD_SUB})
      {`EID_IDX_STAT, `EID_SUB_STAT_IN}:
      begin
        rd_nxt[0] = stat_true_r[od_ch];
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_STAT, `EID_SUB_POS}:
      begin
        rd_nxt = 32'(pos_r[od_ch]);
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_PD, `EID_SUB_PD_INV}:
      begin
        rd_nxt[0] = pd_inv_r[od_ch];
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_SET, `EID_SUB_DIS_FILT}:
        rd_nxt[0] = cfg_r[od_ch].dis_filt;
      {`EID_IDX_SET, `EID_SUB_PLAUS_EN}:
        rd_nxt[0] = cfg_r[od_ch].plaus_en;
      {`EID_IDX_SET2, `EID_SUB_LG_FILT}:
        rd_nxt[0] = cfg_r[od_ch].lg_filt_en;
      {`EID_IDX_DIAG, `EID_SUB_SUP_FAIL}:
      begin
        rd_nxt[0] = sup_fail_r[od_ch];
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_DIAG, `EID_SUB_STAT_ERR}:
      begin
        rd_nxt[0] = stat_err_r[od_ch];
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_DIAG, `EID_SUB_PLAUS_CNT}:
      begin
        rd_nxt = 32'(plaus_cnt_r[od_ch]);
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_DIAG, `EID_SUB_LAT_VIOL}:
      begin
        rd_nxt = 32'(lat_viol_r[od_ch]);
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_DIAG, `EID_SUB_GATE_VIOL}:
      begin
        rd_nxt = 32'(gate_viol_r[od_ch]);
        hit_nxt = !OD_WR;
      end
      {`EID_IDX_DIAG, `EID_SUB_ENC_VIOL}:
      begin
        rd_nxt = 32'(enc_viol_r[od_ch]);
        hit_nxt = !OD_WR;
      end
      default:
      begin
        // Command and restore objects live at single indexes.
        if (OD_INDEX == `EID_IDX_CMD && OD_SUB == `EID_SUB_REQ)
          hit_nxt = 1'b1;
        else if (OD_INDEX == `EID_IDX_RESTORE &&
                 OD_SUB == `EID_SUB_RST_CMD)
          rd_nxt = restore_val_r;
        else if (OD_INDEX == `EID_IDX_RESTORE &&
                 OD_SUB == `EID_SUB_RST_CNT)
        begin
          rd_nxt[7:0] = `EID_RESTORE_ENTRIES;
          hit_nxt = !OD_WR;
        end
        else
          hit_nxt = 1'b0;
      end
    endcase
  end

  // One answer per access, one cycle after it.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= '0;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      ack_r <= OD_RD | OD_WR;
      err_r <= (OD_RD | OD_WR) & ~hit_nxt;
      rdata_r <= (OD_RD && hit_nxt) ? rd_nxt : '0;
    end
  end

  // ==========================================================================
  // Outputs
  assign OD_RDATA = rdata_r;
  assign OD_ACK = ack_r;
  assign OD_ERR = err_r;
  assign LED_SUPPLY_GREEN = led_sup_r;
  assign LED_STATUS_RED = led_stat_r;
  assign PD_INVALID = pd_inv_r;
  assign DIAG = diag_r;

endmodule

`default_nettype wire

// file: sim/eid_enc_model.sv
// Behavioural two-channel quadrature encoder driving the track pins.
`timescale 1ns/1ps
`default_nettype none

module eid_enc_model (
  input wire logic clk,
  input wire logic [1:0] step,
  input wire logic dn,
  input wire logic [1:0] jump,
  output logic [1:0] a,
  output logic [1:0] b
);
  // ========================================================
  // Track generator
  // Both tracks start low, shaft at rest.
  initial
  begin
    a = 2'h0;
    b = 2'h0;
  end

  // A step moves one track, keeping the quarter phase.
  // A jump flips both at once to mimic interference.
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (jump[i])
      begin
        a[i] <= ~a[i];
        b[i] <= ~b[i];
      end
      else if (step[i] && ((a[i] == b[i]) != dn))
        a[i] <= ~a[i];
      else if (step[i])
        b[i] <= ~b[i];
    end
  end
endmodule
`default_nettype wire

// file: sim/eid_top_checker.sv
// Port-level assertions for the encoder diagnostics top module.
`timescale 1ns/1ps
`default_nettype none

module eid_top_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [1:0] COMM_STATE,
  input wire logic OD_WR,
  input wire logic OD_RD,
  input wire logic [1:0] ENC_SUPPLY_OK,
  input wire logic [1:0] STATUS_OVERVOLT,
  input wire logic [31:0] OD_RDATA,
  input wire logic OD_ACK,
  input wire logic OD_ERR,
  input wire logic [1:0] LED_SUPPLY_GREEN,
  input wire logic [1:0] LED_STATUS_RED,
  input wire logic [1:0] PD_INVALID,
  input var eid_pkg::eid_diag_s DIAG
);
  // ========================================================
  // Assertions
  // One domain: clock and reset given once.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_ack;
    (OD_RD || OD_WR) |=> OD_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_noack;
    !(OD_RD || OD_WR) |=> !OD_ACK;
  endproperty
  a_noack: assert property (p_noack) else $error("stray answer");
  property p_err;
    OD_ERR |-> OD_ACK;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_rd0;
    (OD_RDATA != 32'h0) |-> OD_ACK;
  endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  property p_sup_on;
    $rose(ENC_SUPPLY_OK[0]) |-> ##[1:16] LED_SUPPLY_GREEN[0];
  endproperty
  a_sup_on: assert property (p_sup_on) else $error("no green led");
  property p_sup_off;
    $fell(ENC_SUPPLY_OK[0]) |-> ##[1:16] !LED_SUPPLY_GREEN[0];
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("led not off");
  property p_sup_msg;
    $fell(ENC_SUPPLY_OK[0]) |-> ##[1:16] (DIAG.valid && !DIAG.chan &&
      !DIAG.is_error && DIAG.text_id == 16'h8303);
  endproperty
  a_sup_msg: assert property (p_sup_msg) else $error("no supply message");
  property p_ov_led;
    $rose(STATUS_OVERVOLT[1]) |-> ##[1:700] LED_STATUS_RED[1];
  endproperty
  a_ov_led: assert property (p_ov_led) else $error("no red led");
  property p_ov_msg;
    $rose(STATUS_OVERVOLT[1]) |-> ##[1:700] (DIAG.valid && DIAG.chan &&
      DIAG.is_error && DIAG.text_id == 16'h8315);
  endproperty
  a_ov_msg: assert property (p_ov_msg) else $error("no ov message");
  // The invalid mark drops only on a clear or op entry.
  property p_pd;
    $fell(PD_INVALID[0]) |-> ($past(OD_WR) || $past(OD_WR, 2) ||
      COMM_STATE == 2'h2);
  endproperty
  a_pd: assert property (p_pd) else $error("mark dropped");
endmodule

bind eid_top eid_top_checker eid_top_checker_inst (.*);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the encoder input diagnostics.
`timescale 1ns/1ps
`default_nettype none
`include "eid_regs.svh"

module tb;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] exp;
    logic err;
  } eid_row_s;
  // Reset values; last row unmapped.
  eid_row_s rows [10] = '{'{16'h1011, 8'h00, 32'h1, 1'b0},
    '{16'h1011, 8'h01, 32'h0, 1'b0}, '{16'h8000, 8'h08, 32'h1, 1'b0},
    '{16'h8010, 8'h21, 32'h0, 1'b0}, '{16'h8001, 8'h19, 32'h0, 1'b0},
    '{16'hA000, 8'h04, 32'h0, 1'b0}, '{16'h6010, 8'h06, 32'h1, 1'b0},
    '{16'hA010, 8'h13, 32'h0, 1'b0}, '{16'hFB00, 8'h01, 32'h0, 1'b0},
    '{16'h1234, 8'h00, 32'h0, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] step = 2'h0;
  logic [1:0] jump = 2'h0;
  logic dn = 1'b0;
  logic [1:0] enc_a, enc_b, led_g, led_r, pd_inv;
  logic [1:0] latch_in = 2'h0, gate_in = 2'h0, overvolt = 2'h0;
  logic [1:0] status_in = 2'h3, supply_ok = 2'h3, comm = 2'h1;
  logic od_wr = 1'b0, od_rd = 1'b0, od_ack, od_err, er;
  logic [15:0] od_index = 16'h0;
  logic [7:0] od_sub = 8'h0;
  logic [31:0] od_wdata = 32'h0, od_rdata, rd;
  logic [31:0] last_diag = 32'h0;
  eid_pkg::eid_diag_s diag;
  int n_mismatch = 0, n_compared = 0;

  // ========================================================
  // Clock, partner and design
  always #4 clk = ~clk;

  eid_enc_model eid_enc_model_inst (.clk(clk), .step(step), .dn(dn),
    .jump(jump), .a(enc_a), .b(enc_b));

  eid_top eid_top_inst (.CLK(clk), .RST_N(rst_n), .ENC_A(enc_a),
    .ENC_B(enc_b), .LATCH_IN(latch_in), .GATE_IN(gate_in),
    .STATUS_IN(status_in), .ENC_SUPPLY_OK(supply_ok),
    .STATUS_OVERVOLT(overvolt), .COMM_STATE(comm), .OD_WR(od_wr),
    .OD_RD(od_rd), .OD_INDEX(od_index), .OD_SUB(od_sub),
    .OD_WDATA(od_wdata), .OD_RDATA(od_rdata), .OD_ACK(od_ack),
    .OD_ERR(od_err), .LED_SUPPLY_GREEN(led_g), .LED_STATUS_RED(led_r),
    .PD_INVALID(pd_inv), .DIAG(diag));

  // Messages pulse for a cycle; keep the latest.
  always @(posedge clk)
    if (diag.valid === 1'b1)
      last_diag <= {13'h0, diag};

  // ========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One strobe cycle; answer one edge later.
  task automatic od(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd);
    @(posedge clk);
    od_wr <= wr;
    od_rd <= !wr;
    od_index <= idx;
    od_sub <= sub;
    od_wdata <= wd;
    @(posedge clk);
    od_wr <= 1'b0;
    od_rd <= 1'b0;
    #1;
    rd = od_rdata;
    er = od_err;
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] exp);
    od(1'b0, idx, sub, 32'h0);
    chk(rd, exp);
  endtask

  // Leaves time for an unfiltered edge to count.
  task automatic enc(input logic [1:0] s, input logic [1:0] j,
    input logic d);
    @(posedge clk);
    step <= s;
    jump <= j;
    dn <= d;
    @(posedge clk);
    step <= 2'h0;
    jump <= 2'h0;
    wt(10);
  endtask

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ========================================================
  // Sequence
  // The status filter needs 625 cycles, hence long waits.
  initial
  begin
    wt(5);
    rst_n <= 1'b1;
    wt(700);
    foreach (rows[i])
    begin
      od(1'b0, rows[i].idx, rows[i].sub, 32'h0);
      chk(rd, rows[i].exp);
      chk(er, rows[i].err);
    end
    $display("test reset done");
    repeat (4) enc(2'h1, 2'h0, 1'b0);
    rdchk(16'h6000, 8'h11, 32'h4);
    rdchk(16'h6010, 8'h11, 32'h0);
    enc(2'h0, 2'h1, 1'b0);
    rdchk(16'h6000, 8'h11, 32'h4);
    rdchk(16'hA000, 8'h13, 32'h0);
    chk(pd_inv, 2'h0);
    od(1'b1, 16'h8000, 8'h21, 32'h1);
    enc(2'h0, 2'h1, 1'b0);
    chk(last_diag, 32'h00068312);
    rdchk(16'hA000, 8'h13, 32'h1);
    chk(pd_inv, 2'h1);
    rdchk(16'h6000, 8'h11, 32'h4);
    rdchk(16'hA010, 8'h13, 32'h0);
    od(1'b1, 16'hFB00, 8'h01, `EID_REQ_CLR_CH2);
    rdchk(16'hA000, 8'h13, 32'h1);
    od(1'b1, 16'hFB00, 8'h01, `EID_REQ_CLR_CH1);
    rdchk(16'hA000, 8'h13, 32'h0);
    chk(pd_inv, 2'h0);
    enc(2'h0, 2'h1, 1'b0);
    comm <= eid_pkg::EID_SAFEOP;
    wt(2);
    comm <= eid_pkg::EID_OP;
    wt(5);
    rdchk(16'hA000, 8'h13, 32'h0);
    $display("test plausibility done");
    supply_ok <= 2'h2;
    wt(20);
    rdchk(16'hA000, 8'h04, 32'h1);
    chk(led_g, 2'h2);
    supply_ok <= 2'h3;
    overvolt <= 2'h2;
    wt(700);
    rdchk(16'hA010, 8'h05, 32'h1);
    chk(led_r, 2'h2);
    chk(last_diag, 32'h00078315);
    overvolt <= 2'h0;
    status_in <= 2'h2;
    wt(700);
    rdchk(16'h6000, 8'h06, 32'h0);
    chk(led_r, 2'h1);
    status_in <= 2'h3;
    $display("test supply and status done");
    od(1'b1, 16'h8000, 8'h08, 32'h0);
    enc(2'h1, 2'h0, 1'b0);
    enc(2'h1, 2'h0, 1'b1);
    wt(400);
    rdchk(16'hA000, 8'h16, 32'h1);
    rdchk(16'h6000, 8'h11, 32'h4);
    od(1'b1, 16'h8001, 8'h19, 32'h1);
    od(1'b1, 16'h8011, 8'h19, 32'h1);
    latch_in <= 2'h1;
    gate_in <= 2'h2;
    wt(10);
    latch_in <= 2'h0;
    gate_in <= 2'h0;
    wt(100);
    rdchk(16'hA000, 8'h14, 32'h1);
    rdchk(16'hA010, 8'h14, 32'h0);
    rdchk(16'hA010, 8'h15, 32'h1);
    rdchk(16'hA000, 8'h15, 32'h0);
    $display("test filters done");
    od(1'b1, 16'h1011, 8'h01, 32'h64616F6D);
    rdchk(16'h8000, 8'h08, 32'h0);
    od(1'b1, 16'h1011, 8'h01, `EID_RESTORE_MAGIC);
    rdchk(16'h8000, 8'h08, 32'h1);
    rdchk(16'h1011, 8'h01, `EID_RESTORE_MAGIC);
    od(1'b1, 16'h1011, 8'h00, 32'h5);
    chk(er, 1'b1);
    $display("test restore done");
    final_report();
  end

  // About 2800 cycles are needed; 50000 means a hang.
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
